// [design/plsl_pkg.sv]
package plsl_pkg;
  // Clock and timing
  localparam int CLK_MHZ = 25;
  localparam int CLK_PERIOD_NS = 40;
  localparam int ELD_WINDOW_US = 10;
  localparam int ELD_WINDOW_CYC = ELD_WINDOW_US * 1000 / CLK_PERIOD_NS;
  localparam int ELD_WIN_W = 8;
  localparam int ELD_ERR_LIMIT = 32;
  localparam int ELD_ERR_W = 6;
  localparam int BLINK_PERIOD_MS = 50;
  localparam int BLINK_CYC = BLINK_PERIOD_MS * 1000 * CLK_MHZ;
  localparam int STRAP_SETTLE = 3;
  localparam int TX_TAPS = 4;
  // Sizes
  localparam int NUM_PORTS = 3;
  localparam int NUM_IND = 5;
  // Register byte offsets
  localparam logic [7:0] OFS_HARDWARE_CONFIGURATION_REGISTER = 8'h00;
  localparam logic [7:0] OFS_CTRL_CFG = 8'h04;
  localparam logic [7:0] OFS_PWR_CTRL = 8'h08;
  localparam logic [7:0] OFS_RUN_OVR = 8'h0C;
  localparam logic [7:0] OFS_ERR_OVR = 8'h10;
  localparam logic [7:0] OFS_STATUS = 8'h14;
  // Hardware configuration fields
  localparam int HW_POL_LSB = 0;
  localparam int HW_NDA_BIT = 8;
  localparam int HW_NDB_BIT = 9;
  localparam int HW_SHIFT_LSB = 12;
  // Controller configuration fields (loaded from EEPROM)
  localparam int CC_ELD_BIT = 0;
  localparam int CC_SMODE_BIT = 6;
  localparam int CC_ERREN_BIT = 14;
  localparam int CC_MI_BIT = 15;
  localparam logic [15:0] CTRL_CFG_RST = 16'h0000;
  // Power control and override fields
  localparam int PWR_DIS_BIT = 0;
  localparam int OVR_EN_BIT = 0;
  localparam int OVR_VAL_BIT = 1;
  // Status fields
  localparam int ST_LINK_LSB = 0;
  localparam int ST_DROP_LSB = 3;
  localparam int ST_MIOK_LSB = 6;
  localparam int ST_EEERR_BIT = 9;
  localparam int ST_BUSY_BIT = 10;
  // Indicator positions
  localparam int IND_RUN = 0;
  localparam int IND_LINK0 = 1;
  localparam int IND_ERR = 4;
  // PHY control words
  localparam logic [15:0] PHY_WORD_RESTART = 16'h3300;
  localparam logic [15:0] PHY_WORD_RESET = 16'hA100;
  localparam logic [15:0] PHY_WORD_FIXED = 16'h2100;
  // PHY register bit positions
  localparam int BMCR_DUPLEX = 8;
  localparam int BMCR_AN_EN = 12;
  localparam int BMCR_SPEED = 13;
  localparam int BMSR_AN_DONE = 5;
  localparam int ADV_LSB = 5;
  localparam logic [3:0] ADV_ONLY_100FD = 4'h8;
  localparam int GIG_ADV_LSB = 8;
  localparam int LP_100FD = 8;
  // Chip mode where port 2 uses internal PHY A
  localparam logic [1:0] CHIP_MODE_UP = 2'h3;
endpackage

// [design/plsl_tx_shift.sv]
`timescale 1ns/10ps
module plsl_tx_shift (
  input wire logic clk,
  input wire logic nrst,
  input wire logic [1:0] shift_sel,
  input wire logic [3:0] txd_in,
  input wire logic txen_in,
  output logic [3:0] txd,
  output logic txen,
  output logic [plsl_pkg::TX_TAPS-1:0] tap_sel,
  output logic ref_clk_oe
);
  logic [3:0] next_txd;
  logic next_txen;
  logic [plsl_pkg::TX_TAPS-1:0] next_tap;

  // Transmit data timed from the core reference clock
  always_comb
  begin
    next_txd = txd_in;
    next_txen = txen_in;
  end

  // One-hot pad delay tap, 10 ns per step
  genvar t;
  generate
    for (t = 0; t < plsl_pkg::TX_TAPS; t++)
    begin : g_tap
      assign next_tap[t] = (shift_sel == 2'(t));
    end
  endgenerate

  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      txd <= 4'h0;
      txen <= 1'b0;
      tap_sel <= '0;
      ref_clk_oe <= 1'b0;
    end
    else
    begin
      txd <= next_txd;
      txen <= next_txen;
      tap_sel <= next_tap;
      ref_clk_oe <= 1'b1;
    end
  end
endmodule // plsl_tx_shift

// [design/plsl_port_supervisor.sv]
`timescale 1ns/10ps
module plsl_port_supervisor #(
  parameter int BLINK_CYCLES = plsl_pkg::BLINK_CYC
) (
  input wire logic CLK,
  input wire logic NRST,
  input wire logic HSEL,
  input wire logic [31:0] HADDR,
  input wire logic [1:0] HTRANS,
  input wire logic HWRITE,
  input wire logic [2:0] HSIZE,
  input wire logic [31:0] HWDATA,
  input wire logic HREADY,
  output logic [31:0] HRDATA,
  output logic HREADYOUT,
  output logic HRESP,
  input wire logic [1:0] CHIP_MODE,
  input wire logic FIXED_MODE_STRAP_PHY_A,
  input wire logic FIXED_MODE_STRAP_PHY_B,
  input wire logic [1:0] TX_SHIFT_STRAP,
  input wire logic [4:0] INDICATOR_POLARITY_STRAPS,
  input wire logic EE_LOAD_DONE,
  input wire logic EE_LOAD_ERR,
  input wire logic [15:0] EE_CFG_WORD,
  input wire logic [2:0] PORT_LINK,
  input wire logic [2:0] PORT_RX_ER,
  input wire logic [2:0] PORT_RX_DV,
  input wire logic [2:0] PORT_TX_EN,
  input wire logic RUN_REQ,
  input wire logic ERR_REQ,
  input wire logic [3:0] MII_TXD_IN,
  input wire logic MII_TXEN_IN,
  input wire logic PHY_RD_VALID,
  input wire logic [1:0] PHY_RD_PORT,
  input wire logic [15:0] PHY_RD_CTRL,
  input wire logic [15:0] PHY_RD_STAT,
  input wire logic [15:0] PHY_RD_ADV,
  input wire logic [15:0] PHY_RD_GIG,
  input wire logic [15:0] PHY_RD_LP,
  output logic PHY_WR_VALID,
  output logic [1:0] PHY_WR_PORT,
  output logic [15:0] PHY_WR_DATA,
  input wire logic PHY_WR_READY,
  output logic [2:0] LINK_OK,
  output logic NEGOTIATION_DISABLE_PHY_A,
  output logic NEGOTIATION_DISABLE_PHY_B,
  output logic [4:0] IND_OUT,
  output logic [4:0] IND_OE,
  output logic [3:0] MII_TXD,
  output logic MII_TXEN,
  output logic [3:0] TX_TAP_SEL,
  output logic REFERENCE_CLOCK_OUTPUT_OE
);
  localparam int NP = plsl_pkg::NUM_PORTS;
  localparam int BW = $clog2(BLINK_CYCLES + 1);
  localparam int SW = 20;

  // Pin synchronisers
  logic [SW-1:0] sync1, sync2;
  logic [1:0] s_mode, s_shift;
  logic s_fa, s_fb;
  logic [4:0] s_pol;
  logic [2:0] s_link, s_rxer, s_rxdv;
  assign {s_mode, s_fa, s_fb, s_shift, s_pol, s_link, s_rxer, s_rxdv} = sync2;

  always_ff @(posedge CLK)
  begin
    if (!NRST)
    begin
      sync1 <= '0;
      sync2 <= '0;
    end
    else
    begin
      sync1 <= {CHIP_MODE, FIXED_MODE_STRAP_PHY_A, FIXED_MODE_STRAP_PHY_B,
                TX_SHIFT_STRAP, INDICATOR_POLARITY_STRAPS, PORT_LINK,
                PORT_RX_ER, PORT_RX_DV};
      sync2 <= sync1;
    end
  end

  // Bus slave state
  logic wr_pend, next_wr_pend;
  logic [7:0] wr_addr, next_wr_addr;
  logic [31:0] next_rdata;
  logic addr_ok;
  logic ap;

  // Configuration state
  logic [4:0] pol, next_pol;
  logic nda, next_nda, ndb, next_ndb;
  logic [1:0] shift, next_shift;
  logic [1:0] mode, next_mode;
  logic [1:0] settle, next_settle;
  logic taken, next_taken;
  logic [15:0] ccfg, next_ccfg;
  logic first_load, next_first_load;
  logic ee_err, next_ee_err;
  logic pwr_dis, next_pwr_dis;
  logic [1:0] run_ovr, next_run_ovr, err_ovr, next_err_ovr;

  // Per-port supervision state
  logic [NP-1:0] trip, dropped, fixed, mi_ok, next_mi_ok;
  logic [NP-1:0] pend, next_pend;
  logic [15:0] pdata [NP];
  logic [15:0] next_pdata [NP];
  logic busy, next_busy;
  logic [1:0] next_wport;
  logic [15:0] next_wdata;
  logic chk_fail;
  logic [15:0] chk_word;
  logic [31:0] status;

  assign ap = HSEL && HTRANS[1] && HREADY;
  assign addr_ok = (HADDR[31:8] == 24'h0) && (HADDR[1:0] == 2'h0);
  assign status = {21'h0, busy, ee_err, mi_ok, dropped, s_link};

  always_comb
  begin
    next_wr_pend = ap && HWRITE && addr_ok;
    next_wr_addr = HADDR[7:0];
    next_rdata = HRDATA;
    if (ap && !HWRITE)
    begin
      next_rdata = 32'h0;
      if (addr_ok)
      begin
        case (HADDR[7:0])
          plsl_pkg::OFS_HARDWARE_CONFIGURATION_REGISTER:
            next_rdata = {18'h0, shift, 2'h0, ndb, nda, 3'h0, pol};
          plsl_pkg::OFS_CTRL_CFG: next_rdata = {16'h0, ccfg};
          plsl_pkg::OFS_PWR_CTRL: next_rdata = {31'h0, pwr_dis};
          plsl_pkg::OFS_RUN_OVR: next_rdata = {30'h0, run_ovr};
          plsl_pkg::OFS_ERR_OVR: next_rdata = {30'h0, err_ovr};
          plsl_pkg::OFS_STATUS: next_rdata = status;
          default: next_rdata = 32'h0;
        endcase
      end
    end
  end

  always_ff @(posedge CLK)
  begin
    if (!NRST)
    begin
      wr_pend <= 1'b0;
      wr_addr <= 8'h00;
      HRDATA <= 32'h0;
      HREADYOUT <= 1'b1;
      HRESP <= 1'b0;
    end
    else
    begin
      wr_pend <= next_wr_pend;
      wr_addr <= next_wr_addr;
      HRDATA <= next_rdata;
      HREADYOUT <= 1'b1;
      HRESP <= 1'b0;
    end
  end

  // Straps, EEPROM load and software writes
  always_comb
  begin
    next_pol = pol;
    next_nda = nda;
    next_ndb = ndb;
    next_shift = shift;
    next_mode = mode;
    next_settle = settle;
    next_taken = taken;
    next_ccfg = ccfg;
    next_first_load = first_load;
    next_ee_err = ee_err;
    next_pwr_dis = pwr_dis;
    next_run_ovr = run_ovr;
    next_err_ovr = err_ovr;
    if (!taken)
    begin
      if (settle == 2'(plsl_pkg::STRAP_SETTLE))
      begin
        next_taken = 1'b1;
        next_pol = ~s_pol;
        next_nda = s_fa;
        next_ndb = s_fb;
        next_shift = s_shift;
        next_mode = s_mode;
      end
      else
        next_settle = settle + 2'h1;
    end
    if (EE_LOAD_DONE)
    begin
      next_first_load = 1'b0;
      next_ee_err = EE_LOAD_ERR;
      if (!EE_LOAD_ERR)
      begin
        next_ccfg = EE_CFG_WORD;
        if (!first_load)
        begin
          next_ccfg[plsl_pkg::CC_ELD_BIT] = ccfg[plsl_pkg::CC_ELD_BIT];
          next_ccfg[plsl_pkg::CC_MI_BIT] = ccfg[plsl_pkg::CC_MI_BIT];
        end
      end
    end
    if (wr_pend)
    begin
      case (wr_addr)
        plsl_pkg::OFS_HARDWARE_CONFIGURATION_REGISTER:
        begin
          next_pol = HWDATA[plsl_pkg::HW_POL_LSB +: 5];
          next_nda = HWDATA[plsl_pkg::HW_NDA_BIT];
          next_ndb = HWDATA[plsl_pkg::HW_NDB_BIT];
        end
        plsl_pkg::OFS_PWR_CTRL: next_pwr_dis = HWDATA[plsl_pkg::PWR_DIS_BIT];
        plsl_pkg::OFS_RUN_OVR: next_run_ovr = HWDATA[1:0];
        plsl_pkg::OFS_ERR_OVR: next_err_ovr = HWDATA[1:0];
        default: next_pol = pol;
      endcase
    end
  end

  always_ff @(posedge CLK)
  begin
    if (!NRST)
    begin
      pol <= 5'h00;
      nda <= 1'b0;
      ndb <= 1'b0;
      shift <= 2'h0;
      mode <= 2'h0;
      settle <= 2'h0;
      taken <= 1'b0;
      ccfg <= plsl_pkg::CTRL_CFG_RST;
      first_load <= 1'b1;
      ee_err <= 1'b0;
      pwr_dis <= 1'b0;
      run_ovr <= 2'h0;
      err_ovr <= 2'h0;
    end
    else
    begin
      pol <= next_pol;
      nda <= next_nda;
      ndb <= next_ndb;
      shift <= next_shift;
      mode <= next_mode;
      settle <= next_settle;
      taken <= next_taken;
      ccfg <= next_ccfg;
      first_load <= next_first_load;
      ee_err <= next_ee_err;
      pwr_dis <= next_pwr_dis;
      run_ovr <= next_run_ovr;
      err_ovr <= next_err_ovr;
    end
  end

  // Enhanced link detection, one per port
  genvar p;
  generate
    for (p = 0; p < NP; p++)
    begin : g_port
      logic [plsl_pkg::ELD_WIN_W-1:0] win, next_win;
      logic [plsl_pkg::ELD_ERR_W-1:0] errs, next_errs;
      logic next_trip, next_drop;
      logic internal_a;

      assign internal_a = (p == 0) ? (mode != plsl_pkg::CHIP_MODE_UP)
                        : (p == 2) ? (mode == plsl_pkg::CHIP_MODE_UP)
                        : 1'b0;
      assign fixed[p] = (p == 1) ? ndb : (internal_a && nda);

      always_comb
      begin
        next_win = win + 1'b1;
        next_errs = errs;
        if (win == plsl_pkg::ELD_WIN_W'(plsl_pkg::ELD_WINDOW_CYC - 1))
        begin
          next_win = '0;
          next_errs = {5'h0, s_rxer[p]};
        end
        else if (s_rxer[p] &&
                 errs < plsl_pkg::ELD_ERR_W'(plsl_pkg::ELD_ERR_LIMIT))
          next_errs = errs + 1'b1;
        next_trip = ccfg[plsl_pkg::CC_ELD_BIT] && taken && s_rxer[p] &&
                    !dropped[p] && (errs ==
                    plsl_pkg::ELD_ERR_W'(plsl_pkg::ELD_ERR_LIMIT - 1));
        next_drop = dropped[p];
        if (!s_link[p])
          next_drop = 1'b0;
        if (next_trip)
          next_drop = 1'b1;
      end

      always_ff @(posedge CLK)
      begin
        if (!NRST)
        begin
          win <= '0;
          errs <= '0;
          trip[p] <= 1'b0;
          dropped[p] <= 1'b0;
        end
        else
        begin
          win <= next_win;
          errs <= next_errs;
          trip[p] <= next_trip;
          dropped[p] <= next_drop;
        end
      end
    end
  endgenerate

  // Management check of polled PHY registers
  always_comb
  begin
    chk_fail = 1'b0;
    chk_word = plsl_pkg::PHY_WORD_RESTART;
    next_mi_ok = mi_ok;
    if (PHY_RD_VALID && ccfg[plsl_pkg::CC_MI_BIT] && PHY_RD_PORT < 2'h3)
    begin
      if (fixed[PHY_RD_PORT])
      begin
        chk_fail = PHY_RD_CTRL[plsl_pkg::BMCR_AN_EN] ||
                   !PHY_RD_CTRL[plsl_pkg::BMCR_SPEED] ||
                   !PHY_RD_CTRL[plsl_pkg::BMCR_DUPLEX];
        chk_word = plsl_pkg::PHY_WORD_FIXED;
      end
      else
        chk_fail = !PHY_RD_CTRL[plsl_pkg::BMCR_AN_EN] ||
                   (PHY_RD_ADV[plsl_pkg::ADV_LSB +: 4] !=
                    plsl_pkg::ADV_ONLY_100FD) ||
                   (PHY_RD_GIG[plsl_pkg::GIG_ADV_LSB +: 2] != 2'h0) ||
                   !PHY_RD_STAT[plsl_pkg::BMSR_AN_DONE] ||
                   !PHY_RD_LP[plsl_pkg::LP_100FD];
      next_mi_ok[PHY_RD_PORT] = !chk_fail;
    end
  end

  // PHY control write requests, one pending per port
  always_comb
  begin
    next_pend = pend;
    next_busy = busy;
    next_wport = PHY_WR_PORT;
    next_wdata = PHY_WR_DATA;
    for (int i = 0; i < NP; i++)
      next_pdata[i] = pdata[i];
    if (busy && PHY_WR_READY)
      next_busy = 1'b0;
    if (!busy)
    begin
      for (int i = NP - 1; i >= 0; i--)
      begin
        if (pend[i])
        begin
          next_busy = 1'b1;
          next_wport = 2'(i);
          next_wdata = pdata[i];
        end
      end
      if (pend != '0)
        next_pend[next_wport] = 1'b0;
    end
    if (chk_fail)
    begin
      next_pend[PHY_RD_PORT] = 1'b1;
      next_pdata[PHY_RD_PORT] = chk_word;
    end
    for (int i = 0; i < NP; i++)
    begin
      if (trip[i])
      begin
        next_pend[i] = 1'b1;
        next_pdata[i] = fixed[i] ? plsl_pkg::PHY_WORD_RESET
                                 : plsl_pkg::PHY_WORD_RESTART;
      end
    end
  end

  always_ff @(posedge CLK)
  begin
    if (!NRST)
    begin
      pend <= '0;
      busy <= 1'b0;
      mi_ok <= '0;
      PHY_WR_VALID <= 1'b0;
      PHY_WR_PORT <= 2'h0;
      PHY_WR_DATA <= 16'h0;
      for (int i = 0; i < NP; i++)
        pdata[i] <= 16'h0;
    end
    else
    begin
      pend <= next_pend;
      busy <= next_busy;
      mi_ok <= next_mi_ok;
      PHY_WR_VALID <= next_busy;
      PHY_WR_PORT <= next_wport;
      PHY_WR_DATA <= next_wdata;
      for (int i = 0; i < NP; i++)
        pdata[i] <= next_pdata[i];
    end
  end

  // Indicators
  logic [BW-1:0] blink_cnt, next_blink_cnt;
  logic blink, next_blink;
  logic run_raw, err_raw, err_en, err_on, run_on;
  logic [NP-1:0] link_on;
  logic [4:0] ind_on, next_oe;

  always_comb
  begin
    next_blink_cnt = blink_cnt + 1'b1;
    next_blink = blink;
    if (blink_cnt == BW'(BLINK_CYCLES - 1))
    begin
      next_blink_cnt = '0;
      next_blink = !blink;
    end
    run_raw = run_ovr[plsl_pkg::OVR_EN_BIT] ? run_ovr[plsl_pkg::OVR_VAL_BIT]
                                            : RUN_REQ;
    err_raw = err_ovr[plsl_pkg::OVR_EN_BIT] ? err_ovr[plsl_pkg::OVR_VAL_BIT]
                                            : ERR_REQ;
    err_en = ccfg[plsl_pkg::CC_ERREN_BIT] ||
             (ee_err && !pol[plsl_pkg::IND_ERR]);
    err_on = err_raw && err_en;
    run_on = run_raw && !(ccfg[plsl_pkg::CC_SMODE_BIT] && err_on);
    for (int i = 0; i < NP; i++)
      link_on[i] = s_link[i] && !dropped[i] &&
                   !((s_rxdv[i] || PORT_TX_EN[i]) && blink);
    ind_on = {err_on, link_on, run_on};
    next_oe = ind_on & ~{5{pwr_dis}};
  end

  always_ff @(posedge CLK)
  begin
    if (!NRST)
    begin
      blink_cnt <= '0;
      blink <= 1'b0;
      IND_OUT <= 5'h00;
      IND_OE <= 5'h00;
      LINK_OK <= 3'h0;
      NEGOTIATION_DISABLE_PHY_A <= 1'b0;
      NEGOTIATION_DISABLE_PHY_B <= 1'b0;
    end
    else
    begin
      blink_cnt <= next_blink_cnt;
      blink <= next_blink;
      IND_OUT <= pol;
      IND_OE <= next_oe;
      LINK_OK <= s_link & ~dropped;
      NEGOTIATION_DISABLE_PHY_A <= nda;
      NEGOTIATION_DISABLE_PHY_B <= ndb;
    end
  end

  plsl_tx_shift u_tx_shift (
    .clk(CLK),
    .nrst(NRST),
    .shift_sel(shift),
    .txd_in(MII_TXD_IN),
    .txen_in(MII_TXEN_IN),
    .txd(MII_TXD),
    .txen(MII_TXEN),
    .tap_sel(TX_TAP_SEL),
    .ref_clk_oe(REFERENCE_CLOCK_OUTPUT_OE)
  );
endmodule // plsl_port_supervisor

// [dv/plsl_port_supervisor_chk.sv]
`timescale 1ns/10ps
module plsl_port_supervisor_chk (
  input wire logic CLK,
  input wire logic NRST,
  input wire logic [3:0] MII_TXD_IN,
  input wire logic MII_TXEN_IN,
  input wire logic [3:0] MII_TXD,
  input wire logic MII_TXEN,
  input wire logic [3:0] TX_TAP_SEL,
  input wire logic REFERENCE_CLOCK_OUTPUT_OE,
  input wire logic [2:0] PORT_LINK,
  input wire logic [2:0] PORT_RX_ER,
  input wire logic [2:0] LINK_OK,
  input wire logic PHY_WR_VALID,
  input wire logic [1:0] PHY_WR_PORT,
  input wire logic [15:0] PHY_WR_DATA,
  input wire logic PHY_WR_READY,
  input wire logic EE_LOAD_DONE,
  input wire logic EE_LOAD_ERR,
  input wire logic [15:0] EE_CFG_WORD,
  input wire logic HREADYOUT,
  input wire logic HRESP,
  input wire logic NEGOTIATION_DISABLE_PHY_B
);
  logic [7:0] er_run;
  logic [7:0] next_er_run;
  logic [3:0] up;
  logic eld_on, ee_seen;
  default clocking @(posedge CLK);
  endclocking
  default disable iff (!NRST);
  // Length of the current run of receive errors on port 0
  always_comb
  begin
    next_er_run = er_run;
    if (!NRST || !PORT_RX_ER[0])
      next_er_run = 8'h00;
    else if (er_run != 8'hFF)
      next_er_run = er_run + 8'h01;
  end
  always_ff @(posedge CLK)
  begin
    er_run <= next_er_run;
  end
  // Cycles since reset, and detection enable taken at the first load
  always_ff @(posedge CLK)
  begin
    if (!NRST)
    begin
      up <= 4'h0;
      eld_on <= 1'b0;
      ee_seen <= 1'b0;
    end
    else
    begin
      if (up != 4'hF)
        up <= up + 4'h1;
      if (EE_LOAD_DONE && !ee_seen)
      begin
        ee_seen <= 1'b1;
        eld_on <= !EE_LOAD_ERR && EE_CFG_WORD[plsl_pkg::CC_ELD_BIT];
      end
    end
  end
  sequence wr_wait;
    PHY_WR_VALID && !PHY_WR_READY;
  endsequence
  sequence wr_done;
    PHY_WR_VALID && PHY_WR_READY;
  endsequence
  wr_hold_a: assert property (wr_wait |=> PHY_WR_VALID &&
    $stable(PHY_WR_DATA) && $stable(PHY_WR_PORT))
    else $error("phy write request changed before ready");
  wr_release_a: assert property (wr_done |=> !PHY_WR_VALID)
    else $error("phy write request kept after ready");
  wr_word_a: assert property (PHY_WR_VALID |->
    PHY_WR_DATA inside {16'h3300, 16'hA100, 16'h2100})
    else $error("phy write word unknown");
  fixed_word_a: assert property (PHY_WR_VALID && PHY_WR_PORT == 2'h1
    && PHY_WR_DATA != 16'h2100 |-> PHY_WR_DATA ==
    (NEGOTIATION_DISABLE_PHY_B ? 16'hA100 : 16'h3300))
    else $error("restart word does not match fixed mode");
  tap_keep_a: assert property (up == 4'hF |->
    $onehot(TX_TAP_SEL) && $stable(TX_TAP_SEL))
    else $error("tap select not one-hot or not steady");
  tx_pipe_a: assert property ($past(NRST) |->
    MII_TXD == $past(MII_TXD_IN) && MII_TXEN == $past(MII_TXEN_IN))
    else $error("transmit data not one cycle behind input");
  refclk_oe_a: assert property ($past(NRST) |-> REFERENCE_CLOCK_OUTPUT_OE)
    else $error("reference clock output not enabled");
  link_follow_a: assert property (LINK_OK[0] |->
    $past(PORT_LINK[0], 2) || $past(PORT_LINK[0], 3))
    else $error("link ok without link pin");
  burst_drop_a: assert property (eld_on && er_run == 8'h48 |->
    !LINK_OK[0])
    else $error("link kept through receive error burst");
  bus_okay_a: assert property (HREADYOUT && !HRESP)
    else $error("bus slave not ready or not okay");
endmodule // plsl_port_supervisor_chk

// [dv/plsl_phy_model.sv]
`timescale 1ns/10ps
module plsl_phy_model (
  input wire logic clk,
  input wire logic wr_valid,
  input wire logic [1:0] wr_port,
  input wire logic [15:0] wr_data,
  input wire logic [3:0] lat,
  output logic wr_ready,
  output logic rd_valid,
  output logic [1:0] rd_port,
  output logic [15:0] rd_ctrl,
  output logic [15:0] rd_stat,
  output logic [15:0] rd_adv,
  output logic [15:0] rd_gig,
  output logic [15:0] rd_lp
);
  logic [15:0] bmcr [3];
  int wr_count = 0;
  int waited = 0;
  initial
  begin
    wr_ready = 1'h0;
    rd_valid = 1'h0;
    rd_port = 2'h0;
    {rd_ctrl, rd_stat, rd_adv, rd_gig, rd_lp} = 80'h0;
  end
  // Accepts control words after a chosen number of cycles
  always @(posedge clk)
  begin
    if (wr_valid && wr_ready)
    begin
      bmcr[wr_port] <= wr_data;
      wr_count <= wr_count + 1;
      wr_ready <= 1'h0;
      waited <= 0;
    end
    else if (wr_valid)
    begin
      waited <= waited + 1;
      wr_ready <= (waited >= lat);
    end
  end
  // One polled snapshot; lines show garbage once released
  task snap(input logic [1:0] p, input logic [15:0] c, input logic [15:0] a);
    rd_valid <= 1'h1;
    rd_port <= p;
    {rd_ctrl, rd_stat, rd_adv, rd_gig, rd_lp} <= {c, 16'h0020, a, 32'h0100};
    @(posedge clk);
    rd_valid <= 1'h0;
    {rd_ctrl, rd_stat, rd_adv, rd_gig, rd_lp} <= ~{c, 16'h0020, a, 32'h0100};
  endtask
endmodule // plsl_phy_model

// [dv/plsl_port_supervisor_bench.sv]
`timescale 1ns/10ps
module plsl_port_supervisor_bench;
  logic CLK = 1'h0, NRST = 1'h0, HSEL = 1'h0, HWRITE = 1'h0, HREADY;
  logic [31:0] HADDR = 32'h0, HWDATA = 32'h0, HRDATA, rd;
  logic [1:0] HTRANS = 2'h0, CHIP_MODE = 2'h0;
  logic [1:0] TX_SHIFT_STRAP = 2'h3; // Back-to-back setting
  logic [2:0] HSIZE = 3'h2, PORT_LINK = 3'h0, PORT_RX_ER = 3'h0;
  logic [2:0] PORT_RX_DV = 3'h0, PORT_TX_EN = 3'h0, LINK_OK;
  logic FIXED_MODE_STRAP_PHY_A = 1'h0, FIXED_MODE_STRAP_PHY_B = 1'h1;
  logic [4:0] INDICATOR_POLARITY_STRAPS = 5'h0A, IND_OUT, IND_OE;
  logic EE_LOAD_DONE = 1'h0, EE_LOAD_ERR = 1'h0, RUN_REQ = 1'h0;
  logic ERR_REQ = 1'h0, MII_TXEN_IN = 1'h0, MII_TXEN, HREADYOUT, HRESP;
  logic [15:0] EE_CFG_WORD = 16'h0, PHY_WR_DATA, PHY_RD_CTRL, PHY_RD_STAT;
  logic [15:0] PHY_RD_ADV, PHY_RD_GIG, PHY_RD_LP;
  logic [3:0] MII_TXD_IN = 4'h0, lat = 4'h0, MII_TXD, TX_TAP_SEL;
  logic PHY_RD_VALID, PHY_WR_READY, PHY_WR_VALID, REFERENCE_CLOCK_OUTPUT_OE;
  logic NEGOTIATION_DISABLE_PHY_A, NEGOTIATION_DISABLE_PHY_B;
  logic [1:0] PHY_RD_PORT, PHY_WR_PORT;
  int mismatches = 0, total_checks = 0, n, c0;
  assign HREADY = HREADYOUT;
  plsl_port_supervisor #(.BLINK_CYCLES(8)) i_plsl_port_supervisor (.*);
  plsl_phy_model i_plsl_phy_model (.clk(CLK), .wr_valid(PHY_WR_VALID),
    .wr_port(PHY_WR_PORT), .wr_data(PHY_WR_DATA), .lat(lat),
    .wr_ready(PHY_WR_READY), .rd_valid(PHY_RD_VALID), .rd_port(PHY_RD_PORT),
    .rd_ctrl(PHY_RD_CTRL), .rd_stat(PHY_RD_STAT), .rd_adv(PHY_RD_ADV),
    .rd_gig(PHY_RD_GIG), .rd_lp(PHY_RD_LP));
  always #20 CLK = ~CLK;
  always @(posedge CLK)
  begin
    MII_TXD_IN <= MII_TXD_IN + 4'h1;
    MII_TXEN_IN <= MII_TXD_IN[0];
  end
  task end_sim;
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      mismatches++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task cyc(input int k);
    repeat (k) @(posedge CLK);
  endtask
  task rdy;
    n = 0;
    @(posedge CLK);
    while (HREADYOUT !== 1'h1 && n < 20)
    begin
      @(posedge CLK);
      n++;
    end
    if (HREADYOUT !== 1'h1)
    begin
      mismatches++;
      end_sim;
    end
  endtask
  // One single-word transfer; read data lands in rd
  task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    HSEL <= 1'h1;
    HTRANS <= 2'h2;
    HWRITE <= w;
    HADDR <= {24'h0, a};
    rdy;
    HTRANS <= 2'h0;
    HSEL <= 1'h0;
    HWDATA <= d;
    rdy;
    rd = HRDATA;
  endtask
  task wwait(input int target);
    for (n = 0; n < 600 && i_plsl_phy_model.wr_count < target; n++)
      @(posedge CLK);
    if (i_plsl_phy_model.wr_count < target)
    begin
      mismatches++;
      end_sim;
    end
  endtask
  task ee(input logic e, input logic [15:0] w);
    EE_LOAD_DONE <= 1'h1;
    EE_LOAD_ERR <= e;
    EE_CFG_WORD <= w;
    @(posedge CLK);
    EE_LOAD_DONE <= 1'h0;
  endtask
  task tend(input string s);
    $display("test %s done", s);
  endtask
  initial
  begin
    cyc(10);
    NRST <= 1'h1;
    cyc(8);
    bus(0, 8'h00, 0);
    chk(rd, 32'h3215);
    chk(TX_TAP_SEL, 32'h8);
    chk({NEGOTIATION_DISABLE_PHY_A, NEGOTIATION_DISABLE_PHY_B}, 2'h1);
    bus(0, 8'h20, 0);
    chk(rd, 0);
    tend("reset");
    ee(0, 16'h8001);
    RUN_REQ <= 1'h1;
    ERR_REQ <= 1'h1;
    cyc(6);
    chk(IND_OE, 5'h01);
    chk(IND_OUT, 5'h15);
    bus(1, 8'h00, 32'h205);
    ee(1, 16'h0);
    cyc(6);
    chk(IND_OE, 5'h11);
    chk(IND_OUT, 5'h05);
    ee(0, 16'h4040);
    bus(1, 8'h04, 0);
    bus(0, 8'h04, 0);
    chk(rd, 32'hC041);
    cyc(4);
    chk(IND_OE, 5'h10);
    ERR_REQ <= 1'h0;
    bus(1, 8'h10, 32'h3);
    cyc(5);
    chk(IND_OE, 5'h10);
    bus(1, 8'h10, 0);
    bus(1, 8'h0C, 32'h1);
    cyc(5);
    chk(IND_OE, 5'h00);
    bus(1, 8'h0C, 0);
    bus(1, 8'h08, 32'h1);
    cyc(5);
    chk(IND_OE, 5'h00);
    bus(1, 8'h08, 0);
    tend("indicators");
    PORT_LINK <= 3'h1;
    cyc(8);
    chk(IND_OE, 5'h03);
    chk(LINK_OK, 3'h1);
    PORT_TX_EN <= 3'h1;
    c0 = 0;
    repeat (40)
    begin
      @(posedge CLK);
      c0 += IND_OE[1];
    end
    chk(c0 > 0 && c0 < 40, 1);
    PORT_TX_EN <= 3'h0;
    tend("link");
    PORT_LINK <= 3'h7;
    lat <= 4'h3;
    c0 = i_plsl_phy_model.wr_count;
    cyc(8);
    PORT_RX_ER <= 3'h3;
    cyc(80);
    PORT_RX_ER <= 3'h0;
    chk(LINK_OK, 3'h4);
    wwait(c0 + 2);
    chk(i_plsl_phy_model.bmcr[0], 16'h3300);
    chk(i_plsl_phy_model.bmcr[1], 16'hA100);
    PORT_LINK <= 3'h4;
    cyc(6);
    PORT_LINK <= 3'h7;
    cyc(300);
    chk(LINK_OK, 3'h7);
    tend("burst");
    lat <= 4'h0;
    c0 = i_plsl_phy_model.wr_count;
    i_plsl_phy_model.bmcr[0] = 16'h0;
    i_plsl_phy_model.snap(2'h0, 16'h3100, 16'h01E0);
    wwait(c0 + 1);
    chk(i_plsl_phy_model.bmcr[0], 16'h3300);
    i_plsl_phy_model.snap(2'h1, 16'h3100, 16'h0100);
    wwait(c0 + 2);
    chk(i_plsl_phy_model.bmcr[1], 16'h2100);
    i_plsl_phy_model.snap(2'h0, 16'h3100, 16'h0100);
    cyc(20);
    chk(i_plsl_phy_model.wr_count, c0 + 2);
    bus(0, 8'h14, 0);
    chk(rd, 32'h47);
    tend("check");
    NRST <= 1'h0;
    CHIP_MODE <= 2'h3;
    PORT_LINK <= 3'h4;
    cyc(3);
    NRST <= 1'h1;
    cyc(8);
    chk(IND_OE, 5'h09);
    PORT_RX_DV <= 3'h4;
    c0 = 0;
    repeat (40)
    begin
      @(posedge CLK);
      c0 += IND_OE[3];
    end
    chk(c0 > 0 && c0 < 40, 1);
    tend("mode");
    end_sim;
  end
endmodule // plsl_port_supervisor_bench
bind plsl_port_supervisor plsl_port_supervisor_chk i_plsl_port_supervisor_chk (.*);
